// [rtl/vgs_defines.svh]
// Constants for the gain stepper and serial control block
`ifndef VGS_DEFINES_SVH
`define VGS_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define VGS_GAIN_W      6
`define VGS_WORD_W      16
`define VGS_SYNC_W      11

// ----------------------------------------------------------------------
// Serial word field positions
// ----------------------------------------------------------------------
`define VGS_RW_BIT      15
`define VGS_FA_HI       7
`define VGS_FA_LO       6
`define VGS_GAIN_HI     5
`define VGS_GAIN_LO     0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define VGS_GAIN_RESET  6'h3F
`define VGS_FA_RESET    2'h0
`define VGS_GAIN_MAX    7'h3F
`define VGS_STEP_BASE   7'h01
`define VGS_FA_BASE     7'h04
`define VGS_LAST_BIT    5'h0F
`define VGS_WORD_BITS   5'h10
`define VGS_TOP_HALF_DB 8'h28
`define VGS_SYNC_INIT   11'h002

`endif

// [rtl/vgs_pkg.sv]
// Types shared by the gain stepper and serial control block
package vgs_pkg;
  typedef enum logic {VGS_IDLE, VGS_SHIFT} vgs_spi_state_t;
endpackage

// [rtl/vgs_sync.sv]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module vgs_sync #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta     <= INIT;
      sync_out <= INIT;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// [rtl/vgs_top.sv]
// Gain code stepper and three-wire serial gain register
//
// Function
// RULE1 - Direction high: each complete step pulse raises gain one step.
// RULE2 - Direction low: each complete step pulse lowers gain one step.
// RULE3 - Direction differing between pulse rise and fall means stepper reset.
// RULE4 - Stepper reset loads code 63, the minimum gain.
// RULE5 - Step select picks 1, 2, 4 or 8 code units.
// RULE6 - Stepping clamps at codes 0 and 63, never wraps.
// RULE7 - Code 0 is +20 dB, each code lowers 0.5 dB.
// RULE8 - A write is one 16-bit word with read/write flag low.
// RULE9 - Written six gain bits become the attenuation code.
// RULE10 - Written fast-attack bits stored; don't-care bits do nothing.
// RULE11 - A word with read/write flag high requests readback, rest ignored.
// RULE12 - Next transaction the device drives the stored word over 16 clocks.
// RULE13 - Finished readback clears the read request automatically.
// RULE14 - Power-up input low powers down, high enables.
// RULE15 - Interface select: 00 parallel, 01 serial, 1x up/down stepping; the code has no parallel port, so 00 only holds the gain code.
// RULE16 - Controller holds chip select low for exactly 16 serial clocks.
// RULE17 - Fast-attack input high cuts gain by 2, 4, 8 or 16 dB; the code applies it in serial mode only, clamped at code 63.
// RULE18 - Gain code held unless updated; write lands on sixteenth bit.
// RULE19 - Serial data most significant bit first; readback shows stored fields.
`timescale 1ns/1ps
`include "vgs_defines.svh"
module vgs_top import vgs_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        step_pulse_in,
  input  wire logic        step_direction_in,
  input  wire logic        step_size_sel_hi_in,
  input  wire logic        step_size_sel_lo_in,
  input  wire logic        interface_sel_hi_in,
  input  wire logic        interface_sel_lo_in,
  input  wire logic        power_up_in,
  input  wire logic        fast_attack_trigger_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_n_out,
  output logic [5:0]       gain_code_out,
  output logic [5:0]       applied_gain_code_out,
  output logic [7:0]       gain_half_db_out,
  output logic [1:0]       fast_attack_sel_out,
  output logic             read_pending_out,
  output logic             powered_out
);
  // --------------------------------------------------------------------
  // Reset release and pin synchronisation
  // --------------------------------------------------------------------
  logic [1:0]            rst_pipe;
  logic                  rst_n;
  logic [10:0]           pins_sync;
  logic                  s_pulse, s_dir, s_gs1, s_gs0, s_m1, s_m0;
  logic                  s_power_up_in, s_fa, s_sclk, s_csn, s_sdi;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Chip select idles high so no false frame start after reset
  vgs_sync #(.WIDTH(`VGS_SYNC_W), .INIT(`VGS_SYNC_INIT)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .async_in ({step_pulse_in, step_direction_in, step_size_sel_hi_in,
                step_size_sel_lo_in, interface_sel_hi_in, interface_sel_lo_in,
                power_up_in, fast_attack_trigger_in, sclk_in, cs_n_in, sdio_in}),
    .sync_out (pins_sync)
  );
  assign {s_pulse, s_dir, s_gs1, s_gs0, s_m1, s_m0,
          s_power_up_in, s_fa, s_sclk, s_csn, s_sdi} = pins_sync;

  // --------------------------------------------------------------------
  // Edge detection and mode decode
  // --------------------------------------------------------------------
  logic pulse_d, sclk_d, csn_d;
  logic pulse_rise, pulse_fall, sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic mode_updn, mode_serial;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pulse_d <= 1'b0;
      sclk_d  <= 1'b0;
      csn_d   <= 1'b1;
    end else begin
      pulse_d <= s_pulse;
      sclk_d  <= s_sclk;
      csn_d   <= s_csn;
    end
  end

  assign pulse_rise  = s_pulse & ~pulse_d;
  assign pulse_fall  = ~s_pulse & pulse_d;
  assign sclk_rise   = s_sclk & ~sclk_d;
  assign sclk_fall   = ~s_sclk & sclk_d;
  assign cs_fall     = ~s_csn & csn_d;
  assign cs_rise     = s_csn & ~csn_d;
  assign mode_updn   = s_m1;            // see RULE15
  assign mode_serial = ~s_m1 & s_m0;    // see RULE15
  assign powered_out = s_power_up_in;          // see RULE14

  // --------------------------------------------------------------------
  // Up/down stepper
  // --------------------------------------------------------------------
  logic       dir_at_rise, pulse_armed, step_evt, step_reset;
  logic [6:0] step_units, gain7, step_calc;

  // Only a pulse whose rise was seen in stepping mode counts as complete
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dir_at_rise <= 1'b0;
      pulse_armed <= 1'b0;
    end else if (pulse_rise) begin
      dir_at_rise <= s_dir;
      pulse_armed <= mode_updn & s_power_up_in;
    end else if (pulse_fall) begin
      pulse_armed <= 1'b0;
    end
  end

  assign step_evt   = pulse_fall & pulse_armed & mode_updn & s_power_up_in;
  assign step_reset = step_evt & (s_dir != dir_at_rise);                 // see RULE3
  assign step_units = `VGS_STEP_BASE << {s_gs1, s_gs0};                  // see RULE5
  assign gain7      = {1'b0, gain_code_out};

  always_comb begin
    if (s_dir) begin
      step_calc = (gain7 <= step_units) ? 7'h00 : gain7 - step_units;    // see RULE1 RULE6
    end else begin
      step_calc = gain7 + step_units;                                    // see RULE2
      if (step_calc > `VGS_GAIN_MAX) begin
        step_calc = `VGS_GAIN_MAX;                                       // see RULE6
      end
    end
  end

  // --------------------------------------------------------------------
  // Serial port
  // --------------------------------------------------------------------
  vgs_spi_state_t        spi_state;
  logic [4:0]            bit_cnt;
  logic [15:0]           shift_in, shift_out, word_in;
  logic                  driving, word_done, write_commit, read_req, read_done;

  assign word_in      = {shift_in[14:0], s_sdi};                         // see RULE19
  assign word_done    = (spi_state == VGS_SHIFT) & sclk_rise & (bit_cnt == `VGS_LAST_BIT);
  assign write_commit = word_done & ~driving & ~word_in[`VGS_RW_BIT];    // see RULE8 RULE18
  assign read_req     = word_done & ~driving & word_in[`VGS_RW_BIT];     // see RULE11
  assign read_done    = word_done & driving;

  // Frames that start while not in serial mode or powered down are ignored
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      spi_state <= VGS_IDLE;
      bit_cnt   <= 5'h00;
    end else begin
      case (spi_state)
        VGS_IDLE: begin
          if (cs_fall & mode_serial & s_power_up_in) begin
            spi_state <= VGS_SHIFT;
            bit_cnt   <= 5'h00;
          end
        end
        VGS_SHIFT: begin
          if (cs_rise) begin
            spi_state <= VGS_IDLE;
          end else if (sclk_rise & (bit_cnt != `VGS_WORD_BITS)) begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default: spi_state <= VGS_IDLE;
      endcase
    end
  end

  // Extra clocks beyond sixteen are not shifted in
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 16'h0000;
    end else if ((spi_state == VGS_SHIFT) & sclk_rise & (bit_cnt != `VGS_WORD_BITS)) begin
      shift_in <= word_in;
    end
  end

  // Readback presents bit 15 at frame start, next bit after each falling clock
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_out <= 16'h0000;
      driving   <= 1'b0;
    end else if ((spi_state == VGS_IDLE) & cs_fall & mode_serial & s_power_up_in) begin
      shift_out <= {1'b0, 7'h00, fast_attack_sel_out, gain_code_out};    // see RULE19
      driving   <= read_pending_out;                                     // see RULE12
    end else if ((spi_state == VGS_SHIFT) & cs_rise) begin
      driving   <= 1'b0;
    end else if ((spi_state == VGS_SHIFT) & sclk_fall & (bit_cnt != 5'h00)) begin
      shift_out <= {shift_out[14:0], 1'b0};                              // see RULE12
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      read_pending_out <= 1'b0;
    end else if (read_req) begin
      read_pending_out <= 1'b1;                                          // see RULE11
    end else if (read_done) begin
      read_pending_out <= 1'b0;                                          // see RULE13
    end
  end

  assign sdio_out      = shift_out[15];
  assign sdio_oe_n_out = ~driving;

  // --------------------------------------------------------------------
  // Stored gain and fast-attack fields
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gain_code_out <= `VGS_GAIN_RESET;
    end else if (step_reset) begin
      gain_code_out <= `VGS_GAIN_RESET;                                  // see RULE4
    end else if (step_evt) begin
      gain_code_out <= step_calc[5:0];                                   // see RULE1 RULE2
    end else if (write_commit) begin
      gain_code_out <= word_in[`VGS_GAIN_HI:`VGS_GAIN_LO];               // see RULE9
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fast_attack_sel_out <= `VGS_FA_RESET;
    end else if (write_commit) begin
      fast_attack_sel_out <= word_in[`VGS_FA_HI:`VGS_FA_LO];             // see RULE10
    end
  end

  // --------------------------------------------------------------------
  // Applied gain with fast attack
  // --------------------------------------------------------------------
  logic [6:0] fa_units, fa_sum, applied_next;

  // Fast attack only offsets the applied code; the stored code is kept
  assign fa_units = `VGS_FA_BASE << fast_attack_sel_out;
  assign fa_sum   = gain7 + fa_units;
  assign applied_next = (s_fa & mode_serial) ?
                        ((fa_sum > `VGS_GAIN_MAX) ? `VGS_GAIN_MAX : fa_sum) : gain7;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      applied_gain_code_out <= `VGS_GAIN_RESET;
      gain_half_db_out      <= `VGS_TOP_HALF_DB - {2'h0, `VGS_GAIN_RESET};
    end else begin
      applied_gain_code_out <= applied_next[5:0];                        // see RULE17
      gain_half_db_out      <= `VGS_TOP_HALF_DB - {1'b0, applied_next};  // see RULE7
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_step_reset;
    @(posedge clk_in) disable iff (!rst_n)
    step_reset |=> (gain_code_out == 6'h3F);
  endproperty
  a_step_reset: assert property (p_step_reset) else $error("stepper reset missed"); // see RULE4

  property p_step_up;
    @(posedge clk_in) disable iff (!rst_n)
    (step_evt & ~step_reset & s_dir & (gain7 > step_units))
      |=> (gain_code_out == $past(gain7[5:0] - step_units[5:0]));
  endproperty
  a_step_up: assert property (p_step_up) else $error("gain step up wrong"); // see RULE1

  property p_step_down;
    @(posedge clk_in) disable iff (!rst_n)
    (step_evt & ~step_reset & ~s_dir & (gain7 + step_units <= 7'h3F))
      |=> (gain_code_out == $past(gain7[5:0] + step_units[5:0]));
  endproperty
  a_step_down: assert property (p_step_down) else $error("gain step down wrong"); // see RULE2

  property p_clamp;
    @(posedge clk_in) disable iff (!rst_n)
    (step_evt & ~step_reset & s_dir & (gain7 <= step_units)) |=> (gain_code_out == 6'h00);
  endproperty
  a_clamp: assert property (p_clamp) else $error("gain did not clamp at top"); // see RULE6

  property p_write;
    @(posedge clk_in) disable iff (!rst_n)
    write_commit |=> (gain_code_out == $past(word_in[5:0]))
                     && (fast_attack_sel_out == $past(word_in[7:6]));
  endproperty
  a_write: assert property (p_write) else $error("serial write not stored"); // see RULE9

  property p_read_clear;
    @(posedge clk_in) disable iff (!rst_n)
    read_done |=> !read_pending_out;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read flag not cleared"); // see RULE13

  property p_read_drive;
    @(posedge clk_in) disable iff (!rst_n)
    ((spi_state == VGS_IDLE) & cs_fall & mode_serial & s_power_up_in & read_pending_out)
      |=> !sdio_oe_n_out ##0 (sdio_out == 1'b0);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("readback not driven"); // see RULE12

  property p_hold_down;
    @(posedge clk_in) disable iff (!rst_n)
    (!s_power_up_in & $past(!s_power_up_in)) |=> $stable(gain_code_out);
  endproperty
  a_hold_down: assert property (p_hold_down) else $error("gain moved in power-down"); // see RULE18

  property p_fast_attack;
    @(posedge clk_in) disable iff (!rst_n)
    (s_fa & mode_serial & $stable(gain_code_out))
      |=> (applied_gain_code_out >= $past(gain_code_out));
  endproperty
  a_fast_attack: assert property (p_fast_attack) else $error("fast attack raised gain"); // see RULE17
endmodule

// [tb/vgs_ctrl_model.sv]
// Behavioural controller that drives the stepper pins and the three-wire serial port
`timescale 1ns/1ps
module vgs_ctrl_model (
  input  wire logic clk_in,
  input  wire logic sdio_dev_in,
  input  wire logic sdio_oe_n_in,
  output logic      step_pulse_out,
  output logic      step_direction_out,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdio_wire_out
);
  logic ctrl_en;
  logic ctrl_bit;

  // ----------------------------------------------------------------------
  // Shared data line
  // ----------------------------------------------------------------------
  // No pull on the line, so a released line shows the inverse of the last bit
  assign sdio_wire_out = !sdio_oe_n_in ? sdio_dev_in : (ctrl_en ? ctrl_bit : ~ctrl_bit);

  initial begin
    step_pulse_out = 1'b0;
    step_direction_out = 1'b0;
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    ctrl_en = 1'b1;
    ctrl_bit = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One complete pulse; direction may differ between the two edges
  task automatic step(input logic dir_rise, input logic dir_fall);
    step_direction_out = dir_rise;
    hold(4);
    step_pulse_out = 1'b1;
    hold(4);
    step_direction_out = dir_fall;
    hold(4);
    step_pulse_out = 1'b0;
    hold(8);
  endtask

  // Serial clock stands still low outside frames; data changes while it is low
  task automatic frame(input logic [15:0] word, input int nbits, input logic rd,
                       output logic [15:0] got);
    got = 16'h0000;
    ctrl_en = !rd;
    cs_n_out = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      ctrl_bit = word[i];
      hold(4);
      sclk_out = 1'b1;
      hold(4);
      got = {got[14:0], sdio_wire_out};
      sclk_out = 1'b0;
    end
    hold(4);
    cs_n_out = 1'b1;
    ctrl_en = 1'b1;
    hold(6);
  endtask
endmodule

// [tb/tb_vgs_top.sv]
// Self-checking bench for the gain stepper and serial gain register
`timescale 1ns/1ps
module tb_vgs_top;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        sel_hi = 1'b0;
  logic        sel_lo = 1'b0;
  logic        if_hi = 1'b0;
  logic        if_lo = 1'b0;
  logic        pwr = 1'b0;
  logic        fa_trig = 1'b0;
  logic        step_pulse, step_dir, sclk, cs_n, sdio_wire, sdio_out, sdio_oe_n;
  logic        read_pending, powered;
  logic [5:0]  gain_code, applied, exp_code;
  logic [7:0]  half_db;
  logic [1:0]  fa_sel;
  logic [15:0] rd_word;
  logic [6:0]  exp_app;
  int          errors = 0;
  int          checks = 0;

  always #25 clk_in = ~clk_in;

  vgs_top vgs_top_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .step_pulse_in(step_pulse),
    .step_direction_in(step_dir), .step_size_sel_hi_in(sel_hi), .step_size_sel_lo_in(sel_lo),
    .interface_sel_hi_in(if_hi), .interface_sel_lo_in(if_lo), .power_up_in(pwr),
    .fast_attack_trigger_in(fa_trig), .sclk_in(sclk), .cs_n_in(cs_n), .sdio_in(sdio_wire),
    .sdio_out(sdio_out), .sdio_oe_n_out(sdio_oe_n), .gain_code_out(gain_code),
    .applied_gain_code_out(applied), .gain_half_db_out(half_db),
    .fast_attack_sel_out(fa_sel), .read_pending_out(read_pending), .powered_out(powered)
  );

  vgs_ctrl_model vgs_ctrl_model_i (
    .clk_in(clk_in), .sdio_dev_in(sdio_out), .sdio_oe_n_in(sdio_oe_n),
    .step_pulse_out(step_pulse), .step_direction_out(step_dir), .sclk_out(sclk),
    .cs_n_out(cs_n), .sdio_wire_out(sdio_wire)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected code moves only when stepping is selected and powered
  task automatic step_chk(input logic up, input logic [1:0] sel);
    int st;
    st = 1 << sel;
    {sel_hi, sel_lo} = sel;
    vgs_ctrl_model_i.step(up, up);
    if (pwr && if_hi) begin
      if (up) exp_code = (exp_code < st) ? 6'h00 : 6'(exp_code - st);
      else exp_code = (exp_code + st > 63) ? 6'h3F : 6'(exp_code + st);
    end
    chk("gain_code", {10'h000, exp_code}, {10'h000, gain_code});
  endtask

  task automatic wr(input logic [15:0] w);
    vgs_ctrl_model_i.frame(w, 16, 1'b0, rd_word);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    chk("gain_code", 16'h003F, {10'h000, gain_code});
    chk("gain_half_db", 16'h00E9, {8'h00, half_db});
    chk("sdio_oe_n", 16'h0001, {15'h0000, sdio_oe_n});
    reset_n_in = 1'b1;
    pwr = 1'b1;
    if_hi = 1'b1;
    exp_code = 6'h3F;
    vgs_ctrl_model_i.hold(8);
    for (int s = 0; s < 4; s++) step_chk(1'b1, 2'(s));
    step_chk(1'b0, 2'h3);
    for (int i = 0; i < 8; i++) step_chk(1'b1, 2'h3);
    chk("gain_half_db", 16'h0028, {8'h00, half_db});
    for (int i = 0; i < 8; i++) step_chk(1'b0, 2'h3);
    for (int p = 0; p < 2; p++) begin
      step_chk(1'b1, 2'h3);
      vgs_ctrl_model_i.step(p[0], !p[0]);
      exp_code = 6'h3F;
      chk("gain_code", 16'h003F, {10'h000, gain_code});
    end
    step_chk(1'b1, 2'h1);
    pwr = 1'b0;
    vgs_ctrl_model_i.hold(4);
    chk("powered", 16'h0000, {15'h0000, powered});
    step_chk(1'b1, 2'h3);
    pwr = 1'b1;
    if_hi = 1'b0;
    step_chk(1'b1, 2'h3);
    if_hi = 1'b1;
    wr(16'h0015);
    chk("gain_code", {10'h000, exp_code}, {10'h000, gain_code});
    if_hi = 1'b0;
    if_lo = 1'b1;
    wr(16'h7F95);
    chk("gain_code", 16'h0015, {10'h000, gain_code});
    chk("fast_attack_sel", 16'h0002, {14'h0000, fa_sel});
    for (int f = 0; f < 4; f++) begin
      wr({8'h00, 2'(f), 6'h28});
      fa_trig = 1'b1;
      vgs_ctrl_model_i.hold(6);
      exp_app = 7'h28 + (7'h04 << f);
      if (exp_app > 7'h3F) exp_app = 7'h3F;
      chk("applied_gain", {9'h000, exp_app}, {10'h000, applied});
      chk("gain_half_db", {8'h00, 8'h28 - {1'b0, exp_app}}, {8'h00, half_db});
      chk("gain_code", 16'h0028, {10'h000, gain_code});
      fa_trig = 1'b0;
    end
    vgs_ctrl_model_i.frame(16'h0001, 8, 1'b0, rd_word);
    chk("gain_code", 16'h0028, {10'h000, gain_code});
    wr(16'hFFFF);
    chk("read_pending", 16'h0001, {15'h0000, read_pending});
    chk("gain_code", 16'h0028, {10'h000, gain_code});
    vgs_ctrl_model_i.frame(16'h0000, 16, 1'b1, rd_word);
    chk("readback", 16'h00E8, rd_word);
    chk("read_pending", 16'h0000, {15'h0000, read_pending});
    chk("sdio_oe_n", 16'h0001, {15'h0000, sdio_oe_n});
    wr(16'h0007);
    chk("gain_code", 16'h0007, {10'h000, gain_code});
    chk("fast_attack_sel", 16'h0000, {14'h0000, fa_sel});
    results();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (60000) @(posedge clk_in);
    errors++;
    results();
  end
endmodule
